/* File: logic/pcp_port_c_map.vh */
// register offsets, reset values and mode codes of the port c block
`ifndef PCP_PORT_C_MAP_VH
`define PCP_PORT_C_MAP_VH
`define PCP_OFS_DIRECTION 16'hfe3b
`define PCP_OFS_PULLUP 16'hfe42
`define PCP_OFS_OUT_DATA 16'hff0b
`define PCP_OFS_PIN_STATE 16'hffbb
`define PCP_RST_DIRECTION 8'h00
`define PCP_RST_PULLUP 8'h00
`define PCP_RST_OUT_DATA 8'h00
`define PCP_UNDEF_READ 8'h00
`define PCP_MODE_4 3'h4
`define PCP_MODE_5 3'h5
`define PCP_MODE_6 3'h6
`define PCP_MODE_7 3'h7
`define PCP_ADDR_W 18
`endif

/* File: logic/pcp_apb_slave.v */
// apb slave front end: decodes four byte addresses into a one-hot hit vector held for the whole access
`timescale 1ns/1ns
`include "pcp_port_c_map.vh"
module pcp_apb_slave (
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCP_ADDR_W-1:0] paddr,
  output wire acc,
  output wire wr,
  output wire [3:0] hit,
  output wire unmapped
);
  // one-hot hit vector: direction, pullup, out data, pin state
  function [3:0] dec;
    input [`PCP_ADDR_W-1:0] a;
    begin
      if (a == {`PCP_OFS_DIRECTION, 2'b00}) begin
        dec = 4'h1;
      end else if (a == {`PCP_OFS_PULLUP, 2'b00}) begin
        dec = 4'h2;
      end else if (a == {`PCP_OFS_OUT_DATA, 2'b00}) begin
        dec = 4'h4;
      end else if (a == {`PCP_OFS_PIN_STATE, 2'b00}) begin
        dec = 4'h8;
      end else begin
        dec = 4'h0;
      end
    end
  endfunction
  // one wait state (pready from pcp_port_c): every access phase completes at its second edge
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign hit = dec(paddr);
  assign unmapped = (hit == 4'h0);
endmodule // pcp_apb_slave

/* File: logic/pcp_pin_cell.v */
// one port pin: function select, drive enable and pull-up for a single bit
`timescale 1ns/1ns
`include "pcp_port_c_map.vh"
module pcp_pin_cell (
  input wire [2:0] mode,
  input wire dir,
  input wire dout,
  input wire addr_bit,
  input wire pull_en,
  output wire drive,
  output wire level,
  output wire pull
);
  wire addr_mode;
  wire m6;
  wire m7;
  assign m6 = (mode == `PCP_MODE_6);
  assign m7 = (mode == `PCP_MODE_7);
  assign addr_mode = (mode == `PCP_MODE_4) | (mode == `PCP_MODE_5) | (m6 & dir); // [RULE5] [RULE6]
  assign drive = addr_mode | (m7 & dir); // [RULE7]
  assign level = addr_mode ? addr_bit : dout; // [RULE1]
  // only port-input pins in modes 6 and 7 may pull up
  assign pull = (m6 | m7) & ~dir & pull_en; // [RULE13] [RULE14]
endmodule // pcp_pin_cell

/* File: logic/pcp_port_c.v */
// port c: 8-bit general i/o or address output port with apb registers
//
// Function
// [RULE1] eight pins, each general i/o or address output by mode
// [RULE2] direction register is write-only; reads return undefined value
// [RULE3] direction clears on reset and hardware standby, kept in software standby
// [RULE4] output-hold bit picks hold or high-impedance for address pins in software standby
// [RULE5] modes 4 and 5: all pins are address outputs
// [RULE6] mode 6: direction 1 is address output, 0 is input
// [RULE7] mode 7: direction 1 drives data register, 0 is input
// [RULE8] output data register eight bits read/write, clears on reset, kept in standby; the code also clears it in hardware standby
// [RULE9] pin-state register read-only; writes ignored
// [RULE10] pin-state read: data bit where direction 1, pin level where 0
// [RULE11] pin-state follows pins after reset, holds in software standby
// [RULE12] pull-up enable register eight bits read/write, clears, kept in standby; the code also clears it in hardware standby
// [RULE13] pull-up only for input pins in modes 6 and 7
// [RULE14] pull-up on when direction 0 and enable 1
// [RULE15] pull-ups off in reset and hardware standby, frozen in software standby
`timescale 1ns/1ns
`include "pcp_port_c_map.vh"
module pcp_port_c (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PCP_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [2:0] op_mode,
  input wire hw_standby,
  input wire sw_standby,
  input wire standby_output_hold,
  input wire [7:0] addr_out,
  input wire [7:0] io_pins_in,
  output reg [7:0] io_pins_out,
  output reg [7:0] io_pins_oe_n,
  output reg [7:0] io_pins_pullup
);
  reg [7:0] pin_direction_bits;
  reg [7:0] output_data_bits;
  reg [7:0] pullup_enable_bits;
  reg [7:0] pin_level_readback;
  reg [7:0] next_readback;
  wire acc;
  wire wr;
  wire [3:0] hit;
  wire unmapped;
  wire [7:0] drive;
  wire [7:0] level;
  wire [7:0] pull;
  wire [7:0] addr_pin;
  reg [31:0] next_prdata;
  integer i;

  pcp_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .acc(acc),
    .wr(wr),
    .hit(hit),
    .unmapped(unmapped)
  );

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      pcp_pin_cell u_cell (
        .mode(op_mode),
        .dir(pin_direction_bits[g]),
        .dout(output_data_bits[g]),
        .addr_bit(addr_out[g]),
        .pull_en(pullup_enable_bits[g]),
        .drive(drive[g]),
        .level(level[g]),
        .pull(pull[g])
      );
      // drive without data register term means this pin is carrying address
      assign addr_pin[g] = drive[g] & ~((op_mode == `PCP_MODE_7) & pin_direction_bits[g]);
    end
  endgenerate

  // registers; hardware standby acts as a synchronous clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bits <= `PCP_RST_DIRECTION;
      output_data_bits <= `PCP_RST_OUT_DATA;
      pullup_enable_bits <= `PCP_RST_PULLUP;
    end else if (hw_standby) begin
      pin_direction_bits <= `PCP_RST_DIRECTION; // [RULE3]
      output_data_bits <= `PCP_RST_OUT_DATA; // [RULE8]
      pullup_enable_bits <= `PCP_RST_PULLUP; // [RULE12]
    end else if (wr && pready) begin
      // a write lands only at the edge where the master sees pready
      // writes to the pin-state address fall through: nothing stored
      if (hit[0]) begin
        pin_direction_bits <= pwdata[7:0]; // [RULE3]
      end else if (hit[1]) begin
        pullup_enable_bits <= pwdata[7:0]; // [RULE12]
      end else if (hit[2]) begin
        output_data_bits <= pwdata[7:0]; // [RULE8]
      end
    end
  end

  // pin-state sample is frozen in software standby
  always @* begin
    for (i = 0; i < 8; i = i + 1) begin
      next_readback[i] = pin_direction_bits[i] ? output_data_bits[i] : io_pins_in[i]; // [RULE10]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_level_readback <= `PCP_RST_OUT_DATA;
    end else if (hw_standby || !sw_standby) begin
      // after reset the cleared direction bits make this follow the pins
      pin_level_readback <= next_readback; // [RULE11]
    end
  end

  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit[0]) begin
      next_prdata = {24'h00_0000, `PCP_UNDEF_READ}; // [RULE2]
    end else if (hit[1]) begin
      next_prdata = {24'h00_0000, pullup_enable_bits};
    end else if (hit[2]) begin
      next_prdata = {24'h00_0000, output_data_bits}; // [RULE8]
    end else if (hit[3]) begin
      // live value when the sample is running, held value in software standby
      next_prdata = {24'h00_0000, sw_standby ? pin_level_readback : next_readback}; // [RULE9]
    end
  end

  // apb answer: registered, one wait state so outputs come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc & ~pready;
      pslverr <= acc & ~pready & unmapped;
      prdata <= (acc & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
    end
  end

  // pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pins_out <= 8'h00;
      io_pins_oe_n <= 8'hff;
      io_pins_pullup <= 8'h00;
    end else if (hw_standby) begin
      io_pins_out <= 8'h00;
      io_pins_oe_n <= 8'hff;
      io_pins_pullup <= 8'h00; // [RULE15]
    end else if (sw_standby) begin
      // address pins hold or float; port pins and pull-ups keep their state
      io_pins_oe_n <= io_pins_oe_n | (addr_pin & {8{~standby_output_hold}}); // [RULE4]
    end else begin
      io_pins_out <= level; // [RULE1] [RULE7]
      io_pins_oe_n <= ~drive; // [RULE5] [RULE6]
      io_pins_pullup <= pull; // [RULE14]
    end
  end
endmodule // pcp_port_c

/* File: dv/pcp_port_c_assertions.sv */
// concurrent checks on the port c pins and bus answer
`timescale 1ns/1ns
`include "pcp_port_c_map.vh"
module pcp_port_c_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] op_mode,
  input wire hw_standby,
  input wire sw_standby,
  input wire standby_output_hold,
  input wire [7:0] addr_out,
  input wire [7:0] io_pins_out,
  input wire [7:0] io_pins_oe_n,
  input wire [7:0] io_pins_pullup
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_hw_float: assert property (hw_standby[*3] |->
    io_pins_oe_n == 8'hff && io_pins_pullup == 8'h00) else $error("pins not off in standby");
  a_addr_mode: assert property ($past(op_mode[2:1] == 2'b10 && !hw_standby
    && !sw_standby && presetn) |-> io_pins_oe_n == 8'h00 && io_pins_out == $past(addr_out))
    else $error("address not driven");
  a_pull_addr: assert property ($past(op_mode[2:1] == 2'b10 && !sw_standby
    && presetn) |-> io_pins_pullup == 8'h00) else $error("pull-up on address pin");
  a_drive_nopull: assert property ((io_pins_pullup & ~io_pins_oe_n) == 8'h00)
    else $error("pull-up on driven pin");
  a_dir_read: assert property (pready && !pwrite && paddr == {`PCP_OFS_DIRECTION, 2'b00}
    |-> prdata == {24'h0, `PCP_UNDEF_READ}) else $error("direction read not undefined value");
  a_sw_pull: assert property (sw_standby && $past(sw_standby) && $past(sw_standby, 2)
    && !hw_standby |-> $stable(io_pins_pullup)) else $error("pull-up moved in standby");
  a_sw_float: assert property ($past(sw_standby && !standby_output_hold
    && op_mode[2:1] == 2'b10 && presetn) |-> io_pins_oe_n == 8'hff) else $error("no float");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  c_err: cover property (pready && pslverr);
  c_sw: cover property (sw_standby && io_pins_oe_n == 8'hff);
  c_mix: cover property (op_mode == 3'h6 && io_pins_oe_n != 8'hff);
endmodule // pcp_port_c_assertions
bind pcp_port_c pcp_port_c_assertions chk_u (.*);

/* File: dv/pcp_pin_pad.sv */
// pin pad model: resolves port drive, pull-up and an external driver
`timescale 1ns/1ns
module pcp_pin_pad (
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe_n,
  input wire [7:0] pin_pull,
  input wire [7:0] ext,
  input wire [7:0] ext_en,
  output wire [7:0] level
);
  // an undriven, unpulled pin flips so a stale value never reads as a match
  assign level = ~pin_oe_n & pin_out | pin_oe_n & (ext_en & ext | ~ext_en & (pin_pull | ~ext));
endmodule // pcp_pin_pad

/* File: dv/pcp_port_c_tb.sv */
// self-checking bench for the port c block
`timescale 1ns/1ns
`include "pcp_port_c_map.vh"
module pcp_port_c_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [2:0] op_mode = 3'h7;
  logic hw_standby = 0, sw_standby = 0, standby_output_hold = 0;
  logic [7:0] addr_out = 0, ext = 0, en = 0, dir, dat, pu, held;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [7:0] pins_in, pins_out, oe_n, pull;
  int n_fail = 0, tests_run = 0, cyc = 0;
  localparam [17:0] AD = {`PCP_OFS_DIRECTION, 2'b00}, AP = {`PCP_OFS_PULLUP, 2'b00};
  localparam [17:0] AO = {`PCP_OFS_OUT_DATA, 2'b00}, AS = {`PCP_OFS_PIN_STATE, 2'b00};
  pcp_port_c dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_mode(op_mode), .hw_standby(hw_standby), .sw_standby(sw_standby),
    .standby_output_hold(standby_output_hold), .addr_out(addr_out), .io_pins_in(pins_in),
    .io_pins_out(pins_out), .io_pins_oe_n(oe_n), .io_pins_pullup(pull));
  pcp_pin_pad pad_u (.pin_out(pins_out), .pin_oe_n(oe_n), .pin_pull(pull), .ext(ext),
    .ext_en(en), .level(pins_in));
  initial forever #5 pclk = ~pclk;
  function logic [7:0] lvl(input logic [7:0] p);
    return en & ext | ~en & (p | ~ext);
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d}; penable <= 0;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  initial begin
    void'($urandom(70));
    repeat (4) @(posedge pclk);
    presetn <= 1;
    apb(0, AD, 0); chk("dir", rd[7:0], `PCP_UNDEF_READ);
    apb(0, AO, 0); chk("dat", rd[7:0], `PCP_RST_OUT_DATA);
    apb(0, AP, 0); chk("pu", rd[7:0], `PCP_RST_PULLUP);
    apb(0, 18'h00010, 0); chk("err", err, 1);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      dir = i % 16 == 0 ? 0 : i % 16 == 1 ? 8'hff : $urandom; dat = $urandom; pu = $urandom;
      op_mode <= i < 16 ? 3'h7 : 3'h6; addr_out <= $urandom; ext <= $urandom; en <= $urandom;
      apb(1, AD, dir); apb(1, AO, dat); apb(1, AP, pu); repeat (2) @(posedge pclk);
      chk("oe", oe_n, ~dir);
      chk("out", pins_out & dir, (i < 16 ? dat : addr_out) & dir);
      chk("pull", pull, ~dir & pu);
      apb(1, AS, ~dat); apb(0, AS, 0); chk("pin", rd[7:0], dir & dat | ~dir & lvl(pu));
      apb(0, AO, 0); chk("dat", rd[7:0], dat);
    end
    $display("test io done");
    for (int m = 4; m < 6; m++) begin
      op_mode <= m; addr_out <= $urandom; repeat (3) @(posedge pclk);
      chk("oe", oe_n, 8'h00);
      chk("out", pins_out, addr_out);
      chk("pull", pull, 8'h00);
      for (int h = 0; h < 2; h++) begin
        held = addr_out;
        standby_output_hold <= h;
        sw_standby <= 1;
        addr_out <= ~held;
        repeat (3) @(posedge pclk);
        chk("hold", oe_n, h ? 8'h00 : 8'hff);
        chk("keep", pins_out & ~oe_n, held & ~oe_n);
        sw_standby <= 0; repeat (2) @(posedge pclk);
      end
    end
    $display("test address done");
    op_mode <= 7; apb(1, AD, 0); repeat (2) @(posedge pclk); apb(0, AS, 0); held = rd[7:0];
    sw_standby <= 1; ext <= ~ext; en <= 8'hff; repeat (2) @(posedge pclk);
    apb(0, AS, 0); chk("held", rd[7:0], held);
    sw_standby <= 0; apb(1, AO, 8'ha5); apb(1, AD, 8'h3c);
    hw_standby <= 1; repeat (3) @(posedge pclk);
    chk("oe", oe_n, 8'hff);
    chk("pull", pull, 8'h00);
    hw_standby <= 0; repeat (2) @(posedge pclk);
    chk("oe", oe_n, 8'hff);
    apb(0, AO, 0); chk("dat", rd[7:0], 8'h00);
    apb(0, AS, 0); chk("pin", rd[7:0], lvl(8'h00));
    $display("test standby done");
    end_of_test;
  end
endmodule // pcp_port_c_tb
